// >>> design/fpe_pkg.sv
// Constants and types for the flash program/erase timing controller.
// Assumes a 10 MHz reference clock; all waits are derived from it.
package fpe_pkg;
   localparam int CLK_NS      = 100;        // Clock period
   localparam int TMR_W       = 20;         // Wait timer width
   localparam int ITER_W      = 10;         // Iteration counter width
   // Minimum waits in microseconds
   localparam int PG_SWE_US   = 1;          // After write enable set
   localparam int PG_SU_US    = 50;         // After program setup set
   localparam int PG_Z1_US    = 30;         // Pulse, iterations 1..6
   localparam int PG_Z2_US    = 200;        // Pulse, iterations 7..1000
   localparam int PG_Z3_US    = 10;         // Pulse, additional programming
   localparam int PG_PCLR_US  = 5;          // After pulse clear
   localparam int PG_SUCLR_US = 5;          // After setup clear
   localparam int PG_VSET_US  = 4;          // After verify set
   localparam int PG_DW_US    = 2;          // After dummy write
   localparam int PG_VCLR_US  = 2;          // After verify clear
   localparam int ER_SU_US    = 100;        // After erase setup set
   localparam int ER_PCLR_US  = 10;         // After erase pulse clear
   localparam int ER_SUCLR_US = 10;         // After erase setup clear
   localparam int ER_VSET_US  = 20;         // After erase verify set
   localparam int ER_DW_US    = 2;          // After dummy write
   localparam int ER_VCLR_US  = 4;          // After erase verify clear
   localparam int SWE_CLR_US  = 100;        // After write enable clear
   localparam int PG_FAST_N   = 6;          // Iterations with short pulse
   localparam int PG_MAX_N    = 1000;       // Program iteration cap
   localparam int ER_MAX_N    = 120;        // Erase iteration cap
   localparam int ER_TOT_US   = 1200000;    // Erase total time ceiling
   localparam int PG_TOT_US   = 200000;     // Program total time ceiling
   // Register map (byte addresses)
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_ITER   = 8'h08;
   // Field positions
   localparam int CTRL_START = 0;           // Write 1 to start
   localparam int CTRL_ERASE = 1;           // 0 program, 1 erase
   localparam int CTRL_ADDL  = 2;           // Additional programming
   localparam int ST_BUSY    = 0;
   localparam int ST_DONE    = 1;           // Sticky, write 1 to clear
   localparam int ST_PASS    = 2;
   localparam int ST_FAIL    = 3;
   localparam logic [2:0] CTRL_RST = 3'h0;  // Control reset value

   // Cycles for a least time, rounded up
   function automatic logic [TMR_W-1:0] us_cyc(input int us);
      int c;
      c = (us * 1000 + CLK_NS - 1) / CLK_NS;
      if (c < 1) c = 1;
      return TMR_W'(c);
   endfunction : us_cyc

   // Control pins toward the flash
   typedef struct packed {
      logic software_write_enable;
      logic program_setup_bit;
      logic program_pulse_bit;
      logic program_verify_bit;
      logic erase_setup_bit;
      logic erase_pulse_bit;
      logic erase_verify_bit;
      logic dummy_write;
   } fpe_pins_t;

   // Sequencer states
   typedef enum logic [3:0] {
      S_IDLE, S_SWE, S_SU, S_PULSE, S_PCLR, S_SUCLR,
      S_VSET, S_DUMMY, S_DWAIT, S_CHECK, S_VCLR, S_SWECLR
   } fpe_state_t;
endpackage : fpe_pkg

// >>> design/fpe_ctrl.sv
// Flash program/erase timing controller: drives the flash control bits
// Assumes flash verify result arrives as an asynchronous level.
//
// Overview of operation
// - Wait 1 us after write enable set
// - Wait 50 us after program setup set
// - Program pulse 30, 200 or 10 us
// - Wait 5 us after program pulse clear
// - Wait 5 us after program setup clear
// - Wait 4 us after program verify set
// - Wait 2 us after program verify clear
// - Wait 100 us after write enable clear
// - At most 1000 program iterations, 200 ms
// - Wait 100 us after erase setup set
// - Erase pulse between 10 and 100 ms
// - Wait 10 us after erase pulse clear
// - Wait 10 us after erase setup clear
// - Wait 20 us after erase verify set
// - Wait 4 us after erase verify clear
// - At most 120 erase iterations, 1200 ms
`timescale 1ns/100ps
`default_nettype none
module fpe_ctrl
   import fpe_pkg::*;
#(
   parameter int ERASE_PULSE_US = 10000     // Erase pulse width, 10..100 ms
) (
   input  wire logic        REF_CLK,        // 10 MHz clock
   input  wire logic        RST_N,          // Synchronous reset
   input  wire logic [7:0]  REG_ADDR,       // Register address
   input  wire logic [31:0] REG_WDATA,      // Write data
   input  wire logic        REG_WR,         // Write strobe
   input  wire logic        REG_RD,         // Read strobe
   output var  logic [31:0] REG_RDATA,      // Read data, next cycle
   input  wire logic        VERIFY_PASS,    // Flash verify result, async
   output var  fpe_pins_t   FLASH_PINS      // Flash control bits
);
   // Erase pulse in microseconds, kept within its window
   localparam int ER_Z_US  = (ERASE_PULSE_US < 10000) ? 10000 :
                             (ERASE_PULSE_US > 100000) ? 100000 : ERASE_PULSE_US;
   localparam int ER_CAP_T = ER_TOT_US / ER_Z_US;
   localparam int ER_CAP   = (ER_CAP_T < ER_MAX_N) ? ER_CAP_T : ER_MAX_N;
   // Program cap from worst case total pulse time
   localparam int PG_CAP_T = PG_FAST_N + (PG_TOT_US - PG_FAST_N * PG_Z1_US) / PG_Z2_US;
   localparam int PG_CAP   = (PG_CAP_T < PG_MAX_N) ? PG_CAP_T : PG_MAX_N;

   fpe_state_t        state;                // Current step
   fpe_state_t        next_state;           // Step to take
   logic [TMR_W-1:0]  timer;                // Remaining wait in step
   logic [TMR_W-1:0]  next_wait;            // Wait for entered step
   logic [ITER_W-1:0] iter;                 // Pulses issued so far
   logic [ITER_W-1:0] iter_cap;             // Cap for current operation
   logic              op_erase;             // Latched operation
   logic              op_addl;              // Latched additional mode
   logic              ctrl_erase;           // Software operation select
   logic              ctrl_addl;            // Software additional select
   logic              pass_meta;            // Sync stage one
   logic              pass_sync;            // Sync stage two
   logic              pass;                 // Verify result held
   logic              done;                 // Sticky finished flag
   logic              fail;                 // Cap reached without pass
   logic              start;                // Start request
   logic              done_clr;             // Software clears done
   logic              tmo;                  // Wait elapsed
   logic              step;                 // State changes this cycle

   assign start    = REG_WR && REG_ADDR == ADR_CTRL && REG_WDATA[CTRL_START]
                     && state == S_IDLE;
   assign done_clr = REG_WR && REG_ADDR == ADR_STATUS && REG_WDATA[ST_DONE];
   assign tmo      = (timer == '0);
   assign step     = (next_state != state);
   assign iter_cap = op_erase ? ITER_W'(ER_CAP) : ITER_W'(PG_CAP);

   // Two-stage synchroniser for the verify result
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pass_meta <= 1'b0;
         pass_sync <= 1'b0;
      end else begin
         pass_meta <= VERIFY_PASS;
         pass_sync <= pass_meta;
      end
   end

   // Control register
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ctrl_erase <= CTRL_RST[CTRL_ERASE];
         ctrl_addl  <= CTRL_RST[CTRL_ADDL];
      end else if (REG_WR && REG_ADDR == ADR_CTRL) begin
         ctrl_erase <= REG_WDATA[CTRL_ERASE];
         ctrl_addl  <= REG_WDATA[CTRL_ADDL];
      end
   end

   // Step order of one operation
   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE:   if (start) next_state = S_SWE;
         S_SWE:    if (tmo) next_state = S_SU;
         S_SU:     if (tmo) next_state = S_PULSE;
         S_PULSE:  if (tmo) next_state = S_PCLR;
         S_PCLR:   if (tmo) next_state = S_SUCLR;
         S_SUCLR:  if (tmo) next_state = S_VSET;
         S_VSET:   if (tmo) next_state = S_DUMMY;
         S_DUMMY:  next_state = S_DWAIT;              // One-cycle dummy write
         S_DWAIT:  if (tmo) next_state = S_CHECK;
         S_CHECK:  next_state = S_VCLR;               // Sample verify result
         S_VCLR: begin
            // Repeat until pass or cap reached
            if (tmo) begin
               if (pass || iter >= iter_cap) next_state = S_SWECLR;
               else next_state = S_SU;
            end
         end
         S_SWECLR: if (tmo) next_state = S_IDLE;
      endcase
   end

   // Wait length for the step being entered
   always_comb begin
      next_wait = us_cyc(1);
      unique case (next_state)
         S_SWE:    next_wait = us_cyc(PG_SWE_US);
         S_SU:     next_wait = op_erase ? us_cyc(ER_SU_US) : us_cyc(PG_SU_US);
         S_PULSE: begin
            // Pulse width by operation and iteration number
            if (op_erase) next_wait = us_cyc(ER_Z_US);
            else if (op_addl) next_wait = us_cyc(PG_Z3_US);
            else if (iter < ITER_W'(PG_FAST_N)) next_wait = us_cyc(PG_Z1_US);
            else next_wait = us_cyc(PG_Z2_US);
         end
         S_PCLR:   next_wait = op_erase ? us_cyc(ER_PCLR_US) : us_cyc(PG_PCLR_US);
         S_SUCLR:  next_wait = op_erase ? us_cyc(ER_SUCLR_US) : us_cyc(PG_SUCLR_US);
         S_VSET:   next_wait = op_erase ? us_cyc(ER_VSET_US) : us_cyc(PG_VSET_US);
         S_DWAIT:  next_wait = op_erase ? us_cyc(ER_DW_US) : us_cyc(PG_DW_US);
         S_VCLR:   next_wait = op_erase ? us_cyc(ER_VCLR_US) : us_cyc(PG_VCLR_US);
         S_SWECLR: next_wait = us_cyc(SWE_CLR_US);
         default:  next_wait = us_cyc(1);
      endcase
   end

   // State register
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) state <= S_IDLE;
      else state <= next_state;
   end

   // Wait timer: loaded on entry, counts down to zero
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) timer <= '0;
      else if (step) timer <= next_wait - TMR_W'(1);
      else if (!tmo) timer <= timer - TMR_W'(1);
   end

   // Operation latch at start, taken from the start write itself
   // The control flops update on this same edge, so reading them here
   // would pick up the mode of the previous write.
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         op_erase <= 1'b0;
         op_addl  <= 1'b0;
      end else if (start) begin
         op_erase <= REG_WDATA[CTRL_ERASE];
         op_addl  <= REG_WDATA[CTRL_ADDL];
      end
   end

   // Iteration count: one per pulse, only pulse time is budgeted
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) iter <= '0;
      else if (start) iter <= '0;
      else if (step && next_state == S_PULSE) iter <= iter + ITER_W'(1);
   end

   // Verify result held from the check step
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) pass <= 1'b0;
      else if (start) pass <= 1'b0;
      else if (state == S_CHECK) pass <= pass_sync;
   end

   // Done and fail flags; set wins over clear for done, start clear comes first for fail
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         done <= 1'b0;
         fail <= 1'b0;
      end else begin
         if (state == S_SWECLR && tmo) done <= 1'b1;
         else if (done_clr) done <= 1'b0;
         if (start) fail <= 1'b0;
         else if (state == S_VCLR && tmo && !pass && iter >= iter_cap) fail <= 1'b1;
      end
   end

   // Flash control pins, registered from the step entered
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         FLASH_PINS <= '0;
      end else begin
         FLASH_PINS.software_write_enable <= next_state != S_IDLE && next_state != S_SWECLR;
         FLASH_PINS.program_setup_bit  <= !op_erase && next_state inside {S_SU, S_PULSE, S_PCLR};
         FLASH_PINS.program_pulse_bit  <= !op_erase && next_state == S_PULSE;
         FLASH_PINS.program_verify_bit <= !op_erase &&
                                          next_state inside {S_VSET, S_DUMMY, S_DWAIT, S_CHECK};
         FLASH_PINS.erase_setup_bit    <= op_erase && next_state inside {S_SU, S_PULSE, S_PCLR};
         FLASH_PINS.erase_pulse_bit    <= op_erase && next_state == S_PULSE;
         FLASH_PINS.erase_verify_bit   <= op_erase &&
                                          next_state inside {S_VSET, S_DUMMY, S_DWAIT, S_CHECK};
         FLASH_PINS.dummy_write        <= next_state == S_DUMMY;
      end
   end

   // Register read port, data valid one cycle after strobe
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         REG_RDATA <= '0;
      end else begin
         REG_RDATA <= '0;
         if (REG_RD) begin
            unique case (REG_ADDR)
               ADR_CTRL:   REG_RDATA <= {29'h0, ctrl_addl, ctrl_erase, 1'b0};
               ADR_STATUS: REG_RDATA <= {28'h0, fail, pass && done, done,
                                         state != S_IDLE};
               ADR_ITER:   REG_RDATA <= {22'h0, iter};
               default:    REG_RDATA <= '0;
            endcase
         end
      end
   end
endmodule : fpe_ctrl
`default_nettype wire

// >>> dv/fpe_ctrl_chk.sv
// Assertion checker for the flash program/erase timing controller.
// Sees only the controller ports; bound to every controller instance.
`timescale 1ns/100ps
`default_nettype none
module fpe_ctrl_chk
   import fpe_pkg::*;
#(
   parameter int ERASE_PULSE_US = 10000      // Erase pulse width
) (
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic        VERIFY_PASS,
   input wire fpe_pins_t   FLASH_PINS
);
   localparam int EMIN = 100000;             // Shortest erase pulse
   localparam int EMAX = 1000000;            // Longest erase pulse
   fpe_pins_t   p;                           // Short alias
   logic [6:0]  last;                        // Levels without the strobe
   logic [19:0] run;                         // Cycles old levels stood
   logic [9:0]  pcnt;                        // Pulses this operation
   logic        er;                          // Erase operation running
   logic        addl_w;                      // Additional bit last written
   logic        addl;                        // Additional mode of this operation
   assign p = FLASH_PINS;
   // Age of current levels, saturating so reset counts as long idle
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         last <= '0;
         run  <= '1;
      end else begin
         last <= p[7:1];
         run  <= (p[7:1] != last) ? 20'h1 : run + {19'h0, run != '1};
      end
   end
   // Pulse count and mode of the running operation
   always_ff @(posedge REF_CLK) begin
      if (!RST_N || $rose(p.software_write_enable)) begin
         pcnt <= '0;
         er   <= 1'b0;
      end else begin
         if ($rose(p.program_pulse_bit) || $rose(p.erase_pulse_bit)) pcnt <= pcnt + 10'h1;
         if (p.erase_setup_bit) er <= 1'b1;
      end
   end
   // Mode written with the start, captured as the enable rises
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         addl_w <= 1'b0;
         addl   <= 1'b0;
      end else begin
         if (REG_WR && REG_ADDR == ADR_CTRL) addl_w <= REG_WDATA[CTRL_ADDL];
         if ($rose(p.software_write_enable)) addl <= addl_w;
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   a_swe_before_setup: assert property (
      ($rose(p.program_setup_bit) || $rose(p.erase_setup_bit))
      |-> p.software_write_enable && run >= 10) else $error("setup too soon");
   a_setup_before_pulse: assert property (
      $rose(p.program_pulse_bit) |-> p.program_setup_bit && run >= 500)
      else $error("pulse too soon");
   a_prog_pulse_width: assert property (
      $fell(p.program_pulse_bit) |-> (addl ? run inside {[80:120]} :
      (pcnt <= 6 ? run inside {[280:320]} : run inside {[1980:2020]})))
      else $error("program pulse width");
   a_pulse_clr_gap: assert property (
      $fell(p.program_setup_bit) |-> !p.program_pulse_bit && run >= 50)
      else $error("setup cleared early");
   a_setup_clr_gap: assert property (
      $rose(p.program_verify_bit) |-> !p.program_setup_bit && run >= 50)
      else $error("verify set early");
   a_verify_dummy_gap: assert property (
      $rose(p.dummy_write) |-> (run >= (p.erase_verify_bit ? 200 : 40)) ##1 !p.dummy_write)
      else $error("dummy write early");
   a_verify_clr_gap: assert property (
      $fell(p.software_write_enable) |-> run >= (er ? 40 : 20))
      else $error("enable cleared early");
   a_enable_rest: assert property (
      $rose(p.software_write_enable) |-> run >= 1000) else $error("enable restarted early");
   a_iter_cap: assert property (
      ($rose(p.program_pulse_bit) || $rose(p.erase_pulse_bit)) |-> pcnt < (er ? 120 : 1000))
      else $error("too many pulses");
   a_esu_before_pulse: assert property (
      $rose(p.erase_pulse_bit) |-> p.erase_setup_bit && run >= 1000)
      else $error("erase pulse early");
   a_erase_width: assert property (
      $fell(p.erase_pulse_bit) |-> run inside {[EMIN:EMAX]}) else $error("erase pulse width");
   a_erase_gaps: assert property (
      ($fell(p.erase_setup_bit) || $rose(p.erase_verify_bit)) |-> run >= 100)
      else $error("erase step early");
   c_long_pulse: cover property ($fell(p.program_pulse_bit) && pcnt == 7);
   c_erase_done: cover property ($fell(p.erase_pulse_bit));
   c_op_end: cover property ($fell(p.software_write_enable));
endmodule : fpe_ctrl_chk
bind fpe_ctrl fpe_ctrl_chk #(.ERASE_PULSE_US(ERASE_PULSE_US)) fpe_ctrl_chk_i (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .VERIFY_PASS(VERIFY_PASS), .FLASH_PINS(FLASH_PINS));
`default_nettype wire

// >>> dv/fpe_flash_model.sv
// Flash array model: times pulses and answers verify after dummy write.
// Passes once its pulse count reaches the need set by the bench.
`timescale 1ns/100ps
`default_nettype none
module fpe_flash_model
   import fpe_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire fpe_pins_t  pins,             // Control bits from controller
   input  wire logic [9:0] need,             // Pulse count giving a pass
   output var  logic       verify_pass,      // Verify result level
   output var  logic [9:0] pulse_n,          // Pulses seen since reset
   output var  logic [19:0] width            // Length of the last pulse
);
   logic [19:0] run;                         // Current pulse length
   logic        armed;                       // Result valid after dummy write
   // Only pulse time counts toward a unit, verify excluded
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run <= '0;
         width <= '0;
         pulse_n <= '0;
         armed <= 1'b0;
         verify_pass <= 1'b0;
      end else begin
         if (pins.program_pulse_bit || pins.erase_pulse_bit) run <= run + 20'h1;
         else if (run != '0) begin
            width <= run;
            run <= '0;
            pulse_n <= pulse_n + 10'h1;
         end
         if (pins.dummy_write) armed <= 1'b1;
         else if (!(pins.program_verify_bit || pins.erase_verify_bit)) armed <= 1'b0;
         // Released result line toggles so no stale level is seen
         verify_pass <= armed ? (pulse_n >= need) : ~verify_pass;
      end
   end
endmodule : fpe_flash_model
`default_nettype wire

// >>> dv/fpe_ctrl_tb.sv
// Self-checking bench: register port stimulus, flash model on far side.
// Erase runs at the shortest legal pulse; expectations from the package.
`timescale 1ns/100ps
`default_nettype none
module fpe_ctrl_tb;
   import fpe_pkg::*;
   localparam int EP_US = 10000;             // Erase pulse in microseconds
   logic        ref_clk;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        verify_pass;
   fpe_pins_t   flash_pins;
   logic [9:0]  need;
   logic [9:0]  pulse_n;
   logic [19:0] width;
   logic [31:0] d;
   logic [31:0] ctl;
   int          miscompares;
   int          total_checks;
   int          seed;
   fpe_ctrl #(.ERASE_PULSE_US(EP_US)) fpe_ctrl_i (.REF_CLK(ref_clk), .RST_N(rst_n),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .VERIFY_PASS(verify_pass), .FLASH_PINS(flash_pins));
   fpe_flash_model fpe_flash_model_i (.clk(ref_clk), .rst_n(rst_n), .pins(flash_pins),
      .need(need), .verify_pass(verify_pass), .pulse_n(pulse_n), .width(width));
   // Free running clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      v = reg_rdata;
   endtask : rd
   // Expected pulse length in cycles
   function automatic logic [31:0] exp_w(input logic [31:0] c, input int n);
      if (c[CTRL_ERASE]) return EP_US * (1000 / CLK_NS);
      if (c[CTRL_ADDL]) return PG_Z3_US * (1000 / CLK_NS);
      return (n > PG_FAST_N ? PG_Z2_US : PG_Z1_US) * (1000 / CLK_NS);
   endfunction : exp_w
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   // One operation passing after n pulses, with a start while busy
   task automatic run_op(input logic [31:0] c, input int n);
      int i;
      need <= pulse_n + n[9:0];
      wr(ADR_CTRL, c);
      for (i = 0; i < 50 && !flash_pins.software_write_enable; i++) @(posedge ref_clk);
      chk({31'h0, flash_pins.software_write_enable}, 32'h1);
      wr(ADR_CTRL, c);
      d = 32'h1;
      for (i = 0; i < 70000 && d[ST_BUSY]; i++) rd(ADR_STATUS, d);
      if (d[ST_BUSY]) begin
         miscompares++;
         summarize();
      end
      chk(d, (32'h1 << ST_DONE) | (32'h1 << ST_PASS));
      chk({12'h0, width}, exp_w(c, n));
      chk({24'h0, flash_pins}, 32'h0);
      rd(ADR_ITER, d);
      chk(d, n);
      wr(ADR_STATUS, 32'h1 << ST_DONE);
      rd(ADR_STATUS, d);
      chk(d, 32'h0);
   endtask : run_op
   // Reset in mid-pulse drops every pin and clears the status
   task automatic mid_reset();
      int i;
      wr(ADR_CTRL, 32'h1);
      for (i = 0; i < 600 && !flash_pins.program_pulse_bit; i++) @(posedge ref_clk);
      chk({31'h0, flash_pins.program_pulse_bit}, 32'h1);
      rst_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk({24'h0, flash_pins}, 32'h0);
      rd(ADR_STATUS, d);
      chk(d, 32'h0);
   endtask : mid_reset
   // Main sequence
   initial begin
      seed = 32'h646a254c;
      rst_n = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      need = '0;
      miscompares = 0;
      total_checks = 0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk({24'h0, flash_pins}, 32'h0);
      rd(ADR_STATUS, d);
      chk(d, 32'h0);
      ctl = $random(seed) & ~32'h1;
      wr(ADR_CTRL, ctl);
      rd(ADR_CTRL, d);
      chk(d, ctl & 32'h6);
      wr(8'h0c, '1);
      rd(8'h0c, d);
      chk(d, 32'h0);
      mid_reset();
      run_op(32'h1, 1);
      run_op(32'h1, 7);
      run_op(32'h1, 1 + ($unsigned($random(seed)) % 8));
      run_op(32'h5, 1);
      run_op(32'h3, 1);
      summarize();
   end
endmodule : fpe_ctrl_tb
`default_nettype wire
